// ===== hardware_cursor_overlay.sv
// Pointer overlay top: register port, position shadow, pixel compositing
// and palette address steering for the extra look-up entries.
// Assumes video timing inputs are synchronous to sys_clk, one pixel a clock.
// Assumes vid_border is low wherever vid_de is high.
// Assumes patterns are loaded while the pointer is off or away from the beam.
//
// What this block does
// - Bit 0 of attributes enables the pointer; reset leaves it disabled.
// - Attribute bit 1 clear: palette accesses stay standard, no extra entries.
// - Attribute bit 1 set: pointer colours come from dedicated entries.
// - Extra mode: entries 256, 257, 258 reached at locations x0h, xFh, x2h.
// - Entry 256 background, 257 foreground, 258 selectable border colour.
// - X position: low three bits in index bits 7:5, upper eight in data.
// - Y position: low three bits in index bits 7:5, upper eight in data.
// - Pattern select bits 1:0 choose one of four stored patterns.
// - Pointer corner sits at position, measured from active area corner.
// - X counts pixels, Y counts scanlines.
// - Pointer is a 32 by 32 array.
// - Pixel codes: 00 clear, 01 invert video, 10 colour 0, 11 colour 1.
// - New position shows only at the vertical sync after a Y write.
// - Pattern is 256 bytes, 64 per map, invert plane then opaque plane.
`timescale 1ns/1ps
`include "hardware_cursor_overlay_consts.svh"

module hardware_cursor_overlay
    import hardware_cursor_overlay_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic host_data_sel,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_ff,
    input wire logic pat_wr,
    input wire logic [9:0] pat_addr,
    input wire logic [7:0] pat_wdata,
    input wire logic [7:0] pal_host_addr,
    output logic [8:0] pal_lut_addr_ff,
    input wire logic vid_vsync,
    input wire logic vid_de,
    input wire logic vid_border,
    input wire logic [10:0] vid_hcount,
    input wire logic [10:0] vid_vcount,
    input wire logic [7:0] vid_pixel,
    output logic [8:0] out_index_ff,
    output logic out_de_ff,
    output logic out_border_ff
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_ff;
    logic rst_sync_ff;

    // Entry is immediate; release comes two edges late and on a clock edge,
    // so every flop on rst_sync_ff leaves reset together, away from the raw rst_n rise.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    pos_t x_reg;
    pos_t y_reg;
    logic [7:0] attr;
    logic [7:0] pat_sel;
    logic y_write_pulse;
    logic ptr_en;
    logic ext_pal;

    pointer_regs u_regs (
        .sys_clk(sys_clk),
        .rst_sync_n(rst_sync_ff),
        .host_wr(host_wr),
        .host_rd(host_rd),
        .host_data_sel(host_data_sel),
        .host_wdata(host_wdata),
        .host_rdata_ff(host_rdata_ff),
        .x_pos_ff(x_reg),
        .y_pos_ff(y_reg),
        .attr_ff(attr),
        .pat_sel_ff(pat_sel),
        .y_write_pulse(y_write_pulse)
    );

    // Attribute bits above the two flags and pattern bits above 1:0 are kept but unused
    assign ptr_en = attr[`HCO_ATTR_EN_BIT];
    assign ext_pal = attr[`HCO_ATTR_PAL_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Position shadow, reloaded on vertical sync
    // An X write alone never moves the pointer; only a Y write arms the reload

    logic vsync_d_ff;
    logic vsync_rise;
    logic move_pend_ff;
    logic nxt_move_pend;
    pos_t x_show_ff;
    pos_t y_show_ff;

    always_ff @(posedge sys_clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            vsync_d_ff <= 1'b0;
        else
            vsync_d_ff <= vid_vsync;
    end

    assign vsync_rise = vid_vsync & ~vsync_d_ff;

    // A Y write landing on the sync edge keeps the request for the next sync,
    // since the shadow picked up the value from before that write.
    always_comb
    begin
        nxt_move_pend = move_pend_ff;
        if (vsync_rise)
            nxt_move_pend = 1'b0;
        if (y_write_pulse)
            nxt_move_pend = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            move_pend_ff <= 1'b0;
        else
            move_pend_ff <= nxt_move_pend;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
        begin
            x_show_ff <= `HCO_POS_RESET;
            y_show_ff <= `HCO_POS_RESET;
        end
        else if (vsync_rise && move_pend_ff)
        begin
            x_show_ff <= x_reg;
            y_show_ff <= y_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hit test against the 32 x 32 window

    logic [11:0] dx;
    logic [11:0] dy;
    logic in_window;
    ptr_pix_e pix_code;

    // Distance from the pointer corner, one bit wider than the counters so
    // that a count left of or above the corner shows up as a set top bit
    function automatic logic [11:0] corner_offset(input logic [10:0] count, input pos_t corner);
        return {1'b0, count} - {1'b0, corner};
    endfunction

    // The wide compare keeps a corner near the far edge from wrapping round
    function automatic logic in_span(input logic [11:0] offset);
        return offset < 12'(`HCO_PTR_SIZE);
    endfunction

    // Counters are in pixels and scanlines from the first active pixel
    assign dx = corner_offset(vid_hcount, x_show_ff);
    assign dy = corner_offset(vid_vcount, y_show_ff);
    assign in_window = in_span(dx) && in_span(dy);

    // Row and column are don't-care outside the window, where the code is ignored
    pointer_pattern_store u_store (
        .sys_clk(sys_clk),
        .pat_wr(pat_wr),
        .pat_addr(pat_addr),
        .pat_wdata(pat_wdata),
        .rd_pattern(pat_sel[1:0]),
        .rd_row(dy[4:0]),
        .rd_col(dx[4:0]),
        .rd_pix(pix_code)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pixel compositing

    logic [8:0] nxt_out_index;
    logic [8:0] color0;
    logic [8:0] color1;
    logic draw;
    logic border_fill;

    // Without the extra entries the pointer borrows two ordinary entries
    function automatic logic [8:0] color_entry(input logic ext, input logic fg);
        logic [8:0] entry;
        if (ext)
            entry = fg ? `HCO_ENTRY_FG : `HCO_ENTRY_BG;
        else
            entry = fg ? `HCO_COMPAT_FG : `HCO_COMPAT_BG;
        return entry;
    endfunction

    // Clear and invert act on the display pixel, the opaque codes replace it
    function automatic logic [8:0] blend(
        input ptr_pix_e code,
        input logic [7:0] pixel,
        input logic [8:0] c0,
        input logic [8:0] c1
    );
        logic [8:0] shade;
        case (code)
            PIX_CLEAR: shade = {1'b0, pixel};
            PIX_INVERT: shade = {1'b0, ~pixel};
            PIX_COLOR0: shade = c0;
            PIX_COLOR1: shade = c1;
            default: shade = {1'b0, pixel};
        endcase
        return shade;
    endfunction

    assign color0 = color_entry(ext_pal, 1'b0);
    assign color1 = color_entry(ext_pal, 1'b1);
    assign draw = ptr_en && vid_de && in_window;
    // Border fill only outside active video, so the pointer never reaches it
    assign border_fill = vid_border && !vid_de && ext_pal;

    always_comb
    begin
        nxt_out_index = {1'b0, vid_pixel};
        if (border_fill)
            nxt_out_index = `HCO_ENTRY_OVS;
        else if (draw)
            nxt_out_index = blend(pix_code, vid_pixel, color0, color1);
    end

    always_ff @(posedge sys_clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            out_index_ff <= 9'h000;
        else
            out_index_ff <= nxt_out_index;
    end

    // Timing flags keep pace with the composited index
    always_ff @(posedge sys_clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            out_de_ff <= 1'b0;
        else
            out_de_ff <= vid_de;
    end

    always_ff @(posedge sys_clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            out_border_ff <= 1'b0;
        else
            out_border_ff <= vid_border;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Palette address steering for host look-up accesses

    logic [8:0] nxt_pal_addr;

    // Limitation: in the extra mode every location with a matching low nibble
    // lands on the extra entry, so those ordinary entries are shadowed.
    function automatic logic [8:0] steer_pal(input logic ext, input logic [7:0] loc);
        logic [8:0] entry;
        entry = {1'b0, loc};
        if (ext)
        begin
            case (loc[3:0])
                `HCO_SLOT_BG: entry = `HCO_ENTRY_BG;
                `HCO_SLOT_FG: entry = `HCO_ENTRY_FG;
                `HCO_SLOT_OVS: entry = `HCO_ENTRY_OVS;
                default: entry = {1'b0, loc};
            endcase
        end
        return entry;
    endfunction

    always_comb
    begin
        nxt_pal_addr = steer_pal(ext_pal, pal_host_addr);
    end

    always_ff @(posedge sys_clk or negedge rst_sync_ff)
    begin
        if (!rst_sync_ff)
            pal_lut_addr_ff <= 9'h000;
        else
            pal_lut_addr_ff <= nxt_pal_addr;
    end

endmodule

// ===== hardware_cursor_overlay_consts.svh
// Offsets, field positions, reset values and sizes of the pointer overlay.
// Assumes inclusion by bare name from every overlay design file.
`ifndef HARDWARE_CURSOR_OVERLAY_CONSTS_SVH
`define HARDWARE_CURSOR_OVERLAY_CONSTS_SVH

// Low five index bits select the register; bits 7:5 carry position low bits
`define HCO_IDX_X 5'h10
`define HCO_IDX_Y 5'h11
`define HCO_IDX_ATTR 5'h12
`define HCO_IDX_PAT 5'h13
`define HCO_IDX_LSB 0
`define HCO_IDX_MSB 4
`define HCO_POS_LO_LSB 5
`define HCO_POS_LO_MSB 7

`define HCO_ATTR_EN_BIT 0
`define HCO_ATTR_PAL_BIT 1
`define HCO_REG_RESET 8'h00
`define HCO_POS_RESET 11'h000

// Pointer is 32 x 32; each pattern is 4 maps of 64 bytes
`define HCO_PTR_SIZE 32
`define HCO_MAP_BYTES 64
`define HCO_PLANE1_BASE 6'h20

// Extra look-up entries and the palette locations that reach them
`define HCO_ENTRY_BG 9'h100
`define HCO_ENTRY_FG 9'h101
`define HCO_ENTRY_OVS 9'h102
`define HCO_SLOT_BG 4'h0
`define HCO_SLOT_FG 4'hF
`define HCO_SLOT_OVS 4'h2
// Pointer colours used while the extra entries are hidden
`define HCO_COMPAT_BG 9'h000
`define HCO_COMPAT_FG 9'h0FF

`endif

// ===== hardware_cursor_overlay_pkg.sv
// Types and shared decode helpers of the pointer overlay.
// Assumes the constants header is on the include path.
`include "hardware_cursor_overlay_consts.svh"

package hardware_cursor_overlay_pkg;

    typedef enum logic [1:0] {
        PIX_CLEAR = 2'b00,
        PIX_INVERT = 2'b01,
        PIX_COLOR0 = 2'b10,
        PIX_COLOR1 = 2'b11
    } ptr_pix_e;

    typedef logic [10:0] pos_t;

    function automatic logic idx_hit(input logic [7:0] idx, input logic [4:0] sel);
        idx_hit = (idx[`HCO_IDX_MSB:`HCO_IDX_LSB] == sel);
    endfunction

endpackage

// ===== pointer_regs.sv
// Indexed register file: index port plus data port, four pointer registers.
// Assumes host strobes are one-cycle pulses synchronous to sys_clk.
`timescale 1ns/1ps
`include "hardware_cursor_overlay_consts.svh"

module pointer_regs
    import hardware_cursor_overlay_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_sync_n,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic host_data_sel,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata_ff,
    output pos_t x_pos_ff,
    output pos_t y_pos_ff,
    output logic [7:0] attr_ff,
    output logic [7:0] pat_sel_ff,
    output logic y_write_pulse
);

    logic [7:0] index_ff;
    logic idx_wr;
    logic data_wr;

    assign idx_wr = host_wr & ~host_data_sel;
    assign data_wr = host_wr & host_data_sel;
    assign y_write_pulse = data_wr & idx_hit(index_ff, `HCO_IDX_Y);

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            index_ff <= `HCO_REG_RESET;
        else if (idx_wr)
            index_ff <= host_wdata;
    end

    // Low three position bits ride in the index byte
    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            x_pos_ff <= `HCO_POS_RESET;
            y_pos_ff <= `HCO_POS_RESET;
        end
        else
        begin
            if (idx_wr && idx_hit(host_wdata, `HCO_IDX_X))
                x_pos_ff[2:0] <= host_wdata[`HCO_POS_LO_MSB:`HCO_POS_LO_LSB];
            if (data_wr && idx_hit(index_ff, `HCO_IDX_X))
                x_pos_ff[10:3] <= host_wdata;
            if (idx_wr && idx_hit(host_wdata, `HCO_IDX_Y))
                y_pos_ff[2:0] <= host_wdata[`HCO_POS_LO_MSB:`HCO_POS_LO_LSB];
            if (y_write_pulse)
                y_pos_ff[10:3] <= host_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            attr_ff <= `HCO_REG_RESET;
            pat_sel_ff <= `HCO_REG_RESET;
        end
        else
        begin
            if (data_wr && idx_hit(index_ff, `HCO_IDX_ATTR))
                attr_ff <= host_wdata;
            if (data_wr && idx_hit(index_ff, `HCO_IDX_PAT))
                pat_sel_ff <= host_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            host_rdata_ff <= `HCO_REG_RESET;
        else if (host_rd && !host_data_sel)
            host_rdata_ff <= index_ff;
        else if (host_rd)
        begin
            if (idx_hit(index_ff, `HCO_IDX_X))
                host_rdata_ff <= x_pos_ff[10:3];
            else if (idx_hit(index_ff, `HCO_IDX_Y))
                host_rdata_ff <= y_pos_ff[10:3];
            else if (idx_hit(index_ff, `HCO_IDX_ATTR))
                host_rdata_ff <= attr_ff;
            else if (idx_hit(index_ff, `HCO_IDX_PAT))
                host_rdata_ff <= pat_sel_ff;
            else
                host_rdata_ff <= `HCO_REG_RESET;
        end
    end

endmodule

// ===== pointer_pattern_store.sv
// Flip-flop store of four pointer patterns, 256 bytes each.
// Assumes the loader writes whole bytes; reads are combinational.
`timescale 1ns/1ps
`include "hardware_cursor_overlay_consts.svh"

module pointer_pattern_store
    import hardware_cursor_overlay_pkg::*;
(
    input wire logic sys_clk,
    input wire logic pat_wr,
    input wire logic [9:0] pat_addr,
    input wire logic [7:0] pat_wdata,
    input wire logic [1:0] rd_pattern,
    input wire logic [4:0] rd_row,
    input wire logic [4:0] rd_col,
    output ptr_pix_e rd_pix
);

    // Address: pattern[9:8], map[7:6], byte in map[5:0]
    logic [7:0] mem_ff [0:1023];
    logic [9:0] inv_addr;
    logic [9:0] opq_addr;
    logic [2:0] bit_sel;

    always_ff @(posedge sys_clk)
    begin
        if (pat_wr)
            mem_ff[pat_addr] <= pat_wdata;
    end

    // First 32 bytes of a map are the invert plane, last 32 the opaque plane
    assign inv_addr = {rd_pattern, rd_col[4:3], 1'b0, rd_row};
    assign opq_addr = {rd_pattern, rd_col[4:3], 1'b1, rd_row};
    // Map 0 leads the scanline and bit 7 is its first pixel
    assign bit_sel = 3'h7 - rd_col[2:0];
    assign rd_pix = ptr_pix_e'({mem_ff[opq_addr][bit_sel], mem_ff[inv_addr][bit_sel]});

endmodule

// ===== hco_props.sv
// Port checker for the pointer overlay top, attached by bind.
// Assumes one sys_clk domain and host strobes of one cycle.
`timescale 1ns/1ps
`include "hardware_cursor_overlay_consts.svh"
module hco_props
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic host_data_sel,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata_ff,
    input wire logic [7:0] pal_host_addr,
    input wire logic [8:0] pal_lut_addr_ff,
    input wire logic vid_de,
    input wire logic vid_border,
    input wire logic [7:0] vid_pixel,
    input wire logic [8:0] out_index_ff,
    input wire logic out_de_ff,
    input wire logic out_border_ff
);
////////////////////////////////
// Mirrors of the reset release and attribute bits, so checks start with the design
logic [1:0] sync_ff;
logic [7:0] idx_ff;
logic [1:0] attr_ff;
always_ff @(posedge sys_clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        sync_ff <= 2'b00;
        idx_ff <= 8'h00;
        attr_ff <= 2'b00;
    end
    else
    begin
        sync_ff <= {sync_ff[0], 1'b1};
        if (host_wr && !host_data_sel)
            idx_ff <= host_wdata;
        if (host_wr && host_data_sel && idx_ff[4:0] == `HCO_IDX_ATTR)
            attr_ff <= host_wdata[1:0];
    end
end
////////////////////////////////
default clocking cb @(posedge sys_clk); endclocking
default disable iff (!sync_ff[1]);
property p_pal_plain;
    !attr_ff[1] |=> pal_lut_addr_ff == {1'b0, $past(pal_host_addr)};
endproperty
a_pal_plain: assert property (p_pal_plain) else $error("palette address altered");
property p_pal_bg;
    attr_ff[1] && pal_host_addr[3:0] == 4'h0 |=> pal_lut_addr_ff == 9'h100;
endproperty
a_pal_bg: assert property (p_pal_bg) else $error("background entry not reached");
property p_pal_fg;
    attr_ff[1] && pal_host_addr[3:0] == 4'hF |=> pal_lut_addr_ff == 9'h101;
endproperty
a_pal_fg: assert property (p_pal_fg) else $error("foreground entry not reached");
property p_pal_ovs;
    attr_ff[1] && pal_host_addr[3:0] == 4'h2 |=> pal_lut_addr_ff == 9'h102;
endproperty
a_pal_ovs: assert property (p_pal_ovs) else $error("border entry not reached");
property p_disabled;
    !attr_ff[0] && vid_de |=> out_index_ff == {1'b0, $past(vid_pixel)};
endproperty
a_disabled: assert property (p_disabled) else $error("pixel altered while off");
property p_outside;
    !vid_de && !vid_border |=> out_index_ff == {1'b0, $past(vid_pixel)};
endproperty
a_outside: assert property (p_outside) else $error("pixel drawn in blanking");
property p_timing;
    1'b1 |=> out_de_ff == $past(vid_de) && out_border_ff == $past(vid_border);
endproperty
a_timing: assert property (p_timing) else $error("blanking or border flag altered");
property p_border;
    vid_border && !vid_de && attr_ff[1] |=> out_index_ff == 9'h102;
endproperty
a_border: assert property (p_border) else $error("border colour missing");
property p_compat;
    !attr_ff[1] |=> !out_index_ff[8];
endproperty
a_compat: assert property (p_compat) else $error("extra entry used");
property p_rd_hold;
    !host_rd |=> $stable(host_rdata_ff);
endproperty
a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule
bind hardware_cursor_overlay hco_props i_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .host_wr(host_wr), .host_rd(host_rd), .host_data_sel(host_data_sel),
    .host_wdata(host_wdata), .host_rdata_ff(host_rdata_ff),
    .pal_host_addr(pal_host_addr), .pal_lut_addr_ff(pal_lut_addr_ff), .vid_de(vid_de),
    .vid_border(vid_border), .vid_pixel(vid_pixel), .out_index_ff(out_index_ff),
    .out_de_ff(out_de_ff), .out_border_ff(out_border_ff));

// ===== testbench.sv
// Self-checking bench for the pointer overlay: registers, patterns, video.
// Assumes the design files and the checker are compiled ahead of it.
`timescale 1ns/1ps
module testbench;
logic sys_clk, rst_n, host_wr, host_rd, host_data_sel, pat_wr, vid_vsync, vid_de, vid_border;
logic [7:0] host_wdata, pat_wdata, pal_host_addr, vid_pixel, host_rdata_ff;
logic [9:0] pat_addr;
logic [10:0] vid_hcount, vid_vcount, sx, sy, nx, ny;
logic [8:0] pal_lut_addr_ff, out_index_ff;
logic out_de_ff, out_border_ff, m_en, m_pal;
logic [1:0] m_pat;
logic [7:0] mem [0:1023];
logic [31:0] rnd, r;
int error_cnt, total_checks;
int cyc = 0;
hardware_cursor_overlay i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .host_wr(host_wr),
    .host_rd(host_rd), .host_data_sel(host_data_sel), .host_wdata(host_wdata),
    .host_rdata_ff(host_rdata_ff), .pat_wr(pat_wr), .pat_addr(pat_addr),
    .pat_wdata(pat_wdata), .pal_host_addr(pal_host_addr), .pal_lut_addr_ff(pal_lut_addr_ff),
    .vid_vsync(vid_vsync), .vid_de(vid_de), .vid_border(vid_border),
    .vid_hcount(vid_hcount), .vid_vcount(vid_vcount), .vid_pixel(vid_pixel),
    .out_index_ff(out_index_ff), .out_de_ff(out_de_ff), .out_border_ff(out_border_ff));
initial
begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
end
////////////////////////////////
function automatic logic [31:0] rand32();
    rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
    return rnd;
endfunction
function automatic logic [8:0] exp_pix(input logic de, bd, input logic [10:0] h, v,
    input logic [7:0] p);
    logic [10:0] dx, dy;
    logic [1:0] c;
    dx = h - sx;
    dy = v - sy;
    c = 2'b00;
    if (m_en && de && dx < 11'h020 && dy < 11'h020)
        c = {mem[{m_pat, dx[4:3], 1'b1, dy[4:0]}][~dx[2:0]],
             mem[{m_pat, dx[4:3], 1'b0, dy[4:0]}][~dx[2:0]]};
    if (bd && !de && m_pal)
        return 9'h102;
    case (c)
        2'b01: return {1'b0, ~p};
        2'b10: return m_pal ? 9'h100 : 9'h000;
        2'b11: return m_pal ? 9'h101 : 9'h0FF;
        default: return {1'b0, p};
    endcase
endfunction
task automatic chk(input string nm, input logic [10:0] got, input logic [10:0] exp);
    total_checks++;
    if (got !== exp)
    begin
        error_cnt++;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
endtask
// Strobes stay low a full cycle so back-to-back calls never retouch them in one step
task automatic hw(input logic sel, input logic [7:0] d);
    host_wr = 1'b1;
    host_data_sel = sel;
    host_wdata = d;
    @(negedge sys_clk);
    host_wr = 1'b0;
    @(negedge sys_clk);
endtask
task automatic hr(input logic sel, input logic [7:0] e);
    host_rd = 1'b1;
    host_data_sel = sel;
    @(negedge sys_clk);
    host_rd = 1'b0;
    @(negedge sys_clk);
    chk("rdata", 11'(host_rdata_ff), 11'(e));
endtask
task automatic vid(input logic de, bd, input logic [10:0] h, v, input logic [7:0] p, a);
    logic [8:0] e, ea;
    e = exp_pix(de, bd, h, v, p);
    ea = {1'b0, a};
    if (m_pal && a[3:0] == 4'h0) ea = 9'h100;
    if (m_pal && a[3:0] == 4'hF) ea = 9'h101;
    if (m_pal && a[3:0] == 4'h2) ea = 9'h102;
    {vid_de, vid_border, vid_hcount, vid_vcount, vid_pixel, pal_host_addr} = {de, bd, h, v, p, a};
    @(negedge sys_clk);
    chk("out_index", 11'(out_index_ff), 11'(e));
    chk("lut_addr", 11'(pal_lut_addr_ff), 11'(ea));
    chk("out_de", 11'(out_de_ff), 11'(de));
    chk("out_border", 11'(out_border_ff), 11'(bd));
endtask
task automatic sweep();
    for (int j = -1; j < 33; j++)
        for (int k = -1; k < 33; k++)
        begin
            r = rand32();
            vid(r[0] | r[1], r[2], nx + 11'(k), ny + 11'(j), r[15:8], r[23:16]);
        end
endtask
task automatic complete_run();
    if (error_cnt == 0 && total_checks > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask
////////////////////////////////
// About 15k cycles are needed; the ceiling leaves more than twice that
always @(posedge sys_clk)
begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
        error_cnt++;
        complete_run();
    end
end
initial
begin
    {host_wr, host_rd, host_data_sel, host_wdata, pat_wr, pat_addr, pat_wdata} = '0;
    {pal_host_addr, vid_vsync, vid_de, vid_border, vid_hcount, vid_vcount, vid_pixel} = '0;
    {m_en, m_pal, m_pat, sx, sy, nx, ny} = '0;
    rnd = 32'h45EF;
    error_cnt = 0;
    total_checks = 0;
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    // Registers read zero after reset; an undecoded index reads zero as well
    for (int i = 0; i < 5; i++)
    begin
        hw(1'b0, (i == 4) ? 8'h05 : 8'h10 + 8'(i));
        hr(1'b1, 8'h00);
    end
    sweep();
    for (int i = 0; i < 1024; i++)
    begin
        r = rand32();
        mem[i] = r[7:0];
        pat_wr = 1'b1;
        pat_addr = 10'(i);
        pat_wdata = r[7:0];
        @(negedge sys_clk);
    end
    pat_wr = 1'b0;
    for (int t = 0; t < 4; t++)
    begin
        r = rand32();
        nx = (t == 3) ? 11'h000 : {1'b0, r[9:0]};
        ny = (t == 3) ? 11'h000 : {1'b0, r[25:16]};
        m_pal = t[0];
        m_pat = t[1:0];
        hw(1'b0, {nx[2:0], 5'h10});
        hw(1'b1, nx[10:3]);
        hr(1'b1, nx[10:3]);
        hw(1'b0, {ny[2:0], 5'h11});
        hw(1'b1, ny[10:3]);
        hr(1'b1, ny[10:3]);
        hw(1'b0, 8'h33);
        hw(1'b1, {6'h00, m_pat});
        hw(1'b0, 8'h12);
        hw(1'b1, {6'h00, m_pal, 1'b1});
        m_en = 1'b1;
        sweep();
        vid_vsync = 1'b1;
        @(negedge sys_clk);
        vid_vsync = 1'b0;
        sx = nx;
        sy = ny;
        sweep();
    end
    // X alone never moves the pointer; a Y write on the sync edge waits a sync
    r = rand32();
    nx = {1'b0, r[9:0]};
    ny = {1'b0, r[25:16]};
    hw(1'b0, {nx[2:0], 5'h10});
    hw(1'b1, nx[10:3]);
    vid_vsync = 1'b1;
    @(negedge sys_clk);
    vid_vsync = 1'b0;
    hw(1'b0, {ny[2:0], 5'h11});
    {host_wr, host_data_sel, host_wdata, vid_vsync} = {2'b11, ny[10:3], 1'b1};
    @(negedge sys_clk);
    {host_wr, vid_vsync} = 2'b00;
    sweep();
    vid_vsync = 1'b1;
    @(negedge sys_clk);
    vid_vsync = 1'b0;
    sx = nx;
    sy = ny;
    sweep();
    hw(1'b0, 8'h12);
    hw(1'b1, 8'h00);
    m_en = 1'b0;
    m_pal = 1'b0;
    sweep();
    complete_run();
end
endmodule
